// ==== rtl/lsb_pkg.sv ====
/*
 * Constants and types shared by the lock-in status byte bank.
 * Assumes a command decoder on clk_sys that hands over decoded queries.
 */
package lsb_pkg;

	// lock-in status byte bit positions
	localparam int LK_INPUT_OVL   = 0;
	localparam int LK_FILTER_OVL  = 1;
	localparam int LK_OUTPUT_OVL  = 2;
	localparam int LK_LOCK_LOST   = 3;
	localparam int LK_RANGE_SW    = 4;
	localparam int LK_TC_CHANGED  = 5;
	localparam int LK_STORE_EVT   = 6;

	// fault status byte bit positions
	localparam int FT_BACKUP      = 1;
	localparam int FT_RAM         = 2;
	localparam int FT_ROM         = 4;
	localparam int FT_FAST_ABORT  = 5;
	localparam int FT_DSP         = 6;
	localparam int FT_MATH        = 7;

	// bits that exist; all others read as zero
	localparam logic [7:0] LK_LIVE_MASK = 8'h7F;
	localparam logic [7:0] FT_LIVE_MASK = 8'hF6;

	// reset values
	localparam logic [7:0] FLAGS_RESET  = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [4:0] BUS_ADDR_DEF = 5'h08;

	// range switch thresholds, in millihertz
	localparam logic [31:0] FREQ_LOW_MHZ  = 32'h0003_0A2A;
	localparam logic [31:0] FREQ_HIGH_MHZ = 32'h0003_1970;

	// cycles after reset release before pins are sampled at power-up
	localparam logic [1:0] BOOT_SAMPLE_CNT = 2'h2;

	typedef enum logic [2:0] {
		CMD_NONE          = 3'b000,
		CMD_READ_LOCKIN   = 3'b001,
		CMD_READ_FAULT    = 3'b010,
		CMD_READ_LOCK_EN  = 3'b011,
		CMD_READ_FAULT_EN = 3'b100,
		CMD_WRITE_LOCK_EN = 3'b101,
		CMD_WRITE_FLT_EN  = 3'b110
	} lsb_cmd_t;

	// one-hot mask for the single-bit forms of read and write
	function automatic logic [7:0] bitMask(input logic [2:0] sel);
		bitMask = 8'h01 << sel;
	endfunction : bitMask

endpackage : lsb_pkg

// ==== rtl/lsb_sticky_byte.sv ====
/*
 * One sticky event byte: bits set by events, cleared by a clear vector.
 * Assumes set and clear vectors come from logic on clk_sys.
 */
module lsb_sticky_byte #(
	parameter logic [7:0] LIVE_MASK = 8'hFF
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// event and clear vectors
	input  wire logic [7:0] setVec,
	input  wire logic [7:0] clrVec,
	// held flags
	output logic      [7:0] flags_r
);

	logic [7:0] flags_nxt;

	// a set in the same cycle as its clear wins, so no event is lost
	always_comb begin
		flags_nxt = ((flags_r & ~clrVec) | setVec) & LIVE_MASK;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flags_r <= lsb_pkg::FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

endmodule : lsb_sticky_byte

// ==== rtl/lsb_status_bank.sv ====
/*
 * Lock-in and fault status bytes with their enable registers, the
 * detection range tracker and the bus address register.
 * Assumes a command decoder on clk_sys delivers decoded queries and
 * writes as one-cycle strobes, and that the event strobes come from
 * logic on clk_sys. The battery and setup key levels are pins.
 */
module lsb_status_bank #(
	parameter logic [4:0] TC_LIMIT_IDX = 5'h11
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// decoded command port
	input  wire logic        cmdValid,
	input  wire logic [2:0]  cmdCode,
	input  wire logic        cmdBitForm,
	input  wire logic [2:0]  cmdBitSel,
	input  wire logic [7:0]  cmdData,
	input  wire logic        clearStatus,
	// command answers
	output logic      [7:0]  respData_r,
	output logic             respValid_r,
	// lock-in events
	input  wire logic        inputOverload,
	input  wire logic        filterOverload,
	input  wire logic        outputOverload,
	input  wire logic        lockLost,
	input  wire logic        tcIndirectChange,
	input  wire logic        storageTrigger,
	input  wire logic        extTriggerMode,
	// detection frequency and filter settings
	input  wire logic        detFreqValid,
	input  wire logic [31:0] detFreqMhz,
	input  wire logic [4:0]  tcReqIdx,
	input  wire logic        syncFilterReq,
	// fault events
	input  wire logic        ramTestError,
	input  wire logic        romTestError,
	input  wire logic        fastAbort,
	input  wire logic        dspTestError,
	input  wire logic        mathError,
	// pins sampled at power-up
	input  wire logic        batteryFailPin,
	input  wire logic        setupKeyPin,
	// bus address configuration
	input  wire logic        addrWrite,
	input  wire logic [4:0]  addrWriteVal,
	input  wire logic        savedAddrValid,
	input  wire logic [4:0]  savedAddr,
	// status and settings
	output logic      [7:0]  lockinFlags_r,
	output logic      [7:0]  faultFlags_r,
	output logic             lockinSummary_r,
	output logic             faultSummary_r,
	output logic             upperRange_r,
	output logic             syncFilterEn_r,
	output logic      [4:0]  effTcIdx_r,
	output logic      [4:0]  busAddr_r
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	lsb_pkg::lsb_cmd_t cmd;
	logic [7:0] lockinEn_r;
	logic [7:0] faultEn_r;
	logic [7:0] lockinSet;
	logic [7:0] faultSet;
	logic [7:0] lockinClr;
	logic [7:0] faultClr;
	logic [7:0] selMask;
	logic       batterySync1_r;
	logic       batterySync2_r;
	logic       keySync1_r;
	logic       keySync2_r;
	logic [1:0] bootCnt_r;
	logic       bootSample;
	logic       upperRange_nxt;
	logic       rangeSwitch;
	logic [4:0] effTcIdx_nxt;
	logic       tcRangeChange;
	logic [7:0] resp_nxt;
	logic       respIsRead;

	assign cmd     = lsb_pkg::lsb_cmd_t'(cmdCode);
	assign selMask = lsb_pkg::bitMask(cmdBitSel);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and power-up sampling

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			batterySync1_r <= 1'b0;
			batterySync2_r <= 1'b0;
			keySync1_r     <= 1'b0;
			keySync2_r     <= 1'b0;
		end else begin
			batterySync1_r <= batteryFailPin;
			batterySync2_r <= batterySync1_r;
			keySync1_r     <= setupKeyPin;
			keySync2_r     <= keySync1_r;
		end
	end

	// wait until the synchronisers hold pin levels taken after release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bootCnt_r <= 2'h0;
		end else if (bootCnt_r != 2'h3) begin
			bootCnt_r <= bootCnt_r + 2'h1;
		end
	end

	assign bootSample = (bootCnt_r == lsb_pkg::BOOT_SAMPLE_CNT);

	////////////////////////////////////////////////////////////////////////
	// detection range tracking

	// hysteresis between the two thresholds keeps the range from chattering
	always_comb begin
		upperRange_nxt = upperRange_r;
		if (detFreqValid) begin
			if (upperRange_r && (detFreqMhz < lsb_pkg::FREQ_LOW_MHZ)) begin
				upperRange_nxt = 1'b0;
			end else if (!upperRange_r &&
				(detFreqMhz > lsb_pkg::FREQ_HIGH_MHZ)) begin
				upperRange_nxt = 1'b1;
			end
		end
	end

	assign rangeSwitch = (upperRange_nxt != upperRange_r);

	// long time constants are capped in the upper range
	always_comb begin
		effTcIdx_nxt = tcReqIdx;
		if (upperRange_nxt && (tcReqIdx > TC_LIMIT_IDX)) begin
			effTcIdx_nxt = TC_LIMIT_IDX;
		end
	end

	// a cap that appears or goes away with the range is an indirect change
	assign tcRangeChange = rangeSwitch && (effTcIdx_nxt != effTcIdx_r);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			upperRange_r <= 1'b0;
		end else begin
			upperRange_r <= upperRange_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			effTcIdx_r     <= 5'h00;
			syncFilterEn_r <= 1'b0;
		end else begin
			effTcIdx_r     <= effTcIdx_nxt;
			syncFilterEn_r <= syncFilterReq && !upperRange_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event vectors

	always_comb begin
		lockinSet = 8'h00;
		lockinSet[lsb_pkg::LK_INPUT_OVL]  = inputOverload;
		lockinSet[lsb_pkg::LK_FILTER_OVL] = filterOverload;
		lockinSet[lsb_pkg::LK_OUTPUT_OVL] = outputOverload;
		lockinSet[lsb_pkg::LK_LOCK_LOST]  = lockLost;
		lockinSet[lsb_pkg::LK_RANGE_SW]   = rangeSwitch;
		lockinSet[lsb_pkg::LK_TC_CHANGED] =
			tcIndirectChange || tcRangeChange;
		lockinSet[lsb_pkg::LK_STORE_EVT]  =
			storageTrigger && extTriggerMode;
	end

	always_comb begin
		faultSet = 8'h00;
		faultSet[lsb_pkg::FT_BACKUP]     =
			bootSample && batterySync2_r;
		faultSet[lsb_pkg::FT_RAM]        = ramTestError;
		faultSet[lsb_pkg::FT_ROM]        = romTestError;
		faultSet[lsb_pkg::FT_FAST_ABORT] = fastAbort;
		faultSet[lsb_pkg::FT_DSP]        = dspTestError;
		faultSet[lsb_pkg::FT_MATH]       = mathError;
	end

	////////////////////////////////////////////////////////////////////////
	// clear vectors: clear-status, whole-byte read or single-bit read

	always_comb begin
		lockinClr = 8'h00;
		faultClr  = 8'h00;
		if (clearStatus) begin
			lockinClr = 8'hFF;
			faultClr  = 8'hFF;
		end
		if (cmdValid && (cmd == lsb_pkg::CMD_READ_LOCKIN)) begin
			lockinClr = lockinClr |
				(cmdBitForm ? selMask : 8'hFF);
		end
		if (cmdValid && (cmd == lsb_pkg::CMD_READ_FAULT)) begin
			faultClr = faultClr |
				(cmdBitForm ? selMask : 8'hFF);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the two sticky bytes

	lsb_sticky_byte #(
		.LIVE_MASK (lsb_pkg::LK_LIVE_MASK)
	) u_lockin (
		.clk_sys (clk_sys),
		.rst     (rst),
		.setVec  (lockinSet),
		.clrVec  (lockinClr),
		.flags_r (lockinFlags_r)
	);

	lsb_sticky_byte #(
		.LIVE_MASK (lsb_pkg::FT_LIVE_MASK)
	) u_fault (
		.clk_sys (clk_sys),
		.rst     (rst),
		.setVec  (faultSet),
		.clrVec  (faultClr),
		.flags_r (faultFlags_r)
	);

	////////////////////////////////////////////////////////////////////////
	// enable registers

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lockinEn_r <= lsb_pkg::ENABLE_RESET;
		end else if (cmdValid && (cmd == lsb_pkg::CMD_WRITE_LOCK_EN)) begin
			if (cmdBitForm) begin
				lockinEn_r <= cmdData[0] ? (lockinEn_r | selMask)
					: (lockinEn_r & ~selMask);
			end else begin
				lockinEn_r <= cmdData;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			faultEn_r <= lsb_pkg::ENABLE_RESET;
		end else if (cmdValid && (cmd == lsb_pkg::CMD_WRITE_FLT_EN)) begin
			if (cmdBitForm) begin
				faultEn_r <= cmdData[0] ? (faultEn_r | selMask)
					: (faultEn_r & ~selMask);
			end else begin
				faultEn_r <= cmdData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// summary bits for the serial poll byte

	// follows the held flags, so it drops only when every enabled bit is gone
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lockinSummary_r <= 1'b0;
			faultSummary_r  <= 1'b0;
		end else begin
			lockinSummary_r <= |(lockinFlags_r & lockinEn_r);
			faultSummary_r  <= |(faultFlags_r & faultEn_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// query answers

	// reads show the flags as held before this cycle's clear takes effect
	always_comb begin
		resp_nxt   = 8'h00;
		respIsRead = 1'b1;
		case (cmd)
			lsb_pkg::CMD_READ_LOCKIN: begin
				resp_nxt = lockinFlags_r;
			end
			lsb_pkg::CMD_READ_FAULT: begin
				resp_nxt = faultFlags_r;
			end
			lsb_pkg::CMD_READ_LOCK_EN: begin
				resp_nxt = lockinEn_r;
			end
			lsb_pkg::CMD_READ_FAULT_EN: begin
				resp_nxt = faultEn_r;
			end
			default: begin
				respIsRead = 1'b0;
			end
		endcase
		if (cmdBitForm) begin
			resp_nxt = {7'h00, |(resp_nxt & selMask)};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			respData_r  <= 8'h00;
			respValid_r <= 1'b0;
		end else begin
			respValid_r <= cmdValid && respIsRead;
			if (cmdValid && respIsRead) begin
				respData_r <= resp_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus address

	// a configured address survives power-up only without the setup key
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busAddr_r <= lsb_pkg::BUS_ADDR_DEF;
		end else if (bootSample) begin
			if (keySync2_r || !savedAddrValid) begin
				busAddr_r <= lsb_pkg::BUS_ADDR_DEF;
			end else begin
				busAddr_r <= savedAddr;
			end
		end else if (addrWrite) begin
			busAddr_r <= addrWriteVal;
		end
	end

endmodule : lsb_status_bank

// ==== testbench/lsb_status_bank_props.sv ====
/* Checker for the status byte bank, bound to the bank.
   Assumes one clk_sys domain with synchronous rst. */
module lsb_status_bank_props (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// command port
	input wire logic       cmdValid,
	input wire logic [2:0] cmdCode,
	input wire logic       cmdBitForm,
	input wire logic       clearStatus,
	// events
	input wire logic       inputOverload,
	input wire logic       storageTrigger,
	input wire logic       extTriggerMode,
	input wire logic       mathError,
	// outputs
	input wire logic [7:0] respData_r,
	input wire logic       respValid_r,
	input wire logic [7:0] lockinFlags_r,
	input wire logic [7:0] faultFlags_r,
	input wire logic       lockinSummary_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	AST_IN_OVL: assert property (
		inputOverload |=> lockinFlags_r[0])
		else $error("input overload not flagged");
	AST_STORE_EVT: assert property (
		storageTrigger && extTriggerMode |=> lockinFlags_r[6])
		else $error("storage trigger not flagged");
	AST_LK_HOLD: assert property (
		lockinFlags_r[0] && !clearStatus && !(cmdValid && cmdCode == 3'h1)
		|=> lockinFlags_r[0])
		else $error("lock-in flag dropped");
	AST_CLS: assert property (
		clearStatus && !inputOverload |=> !lockinFlags_r[0])
		else $error("clear status left a flag");
	AST_MATH: assert property (
		mathError |=> faultFlags_r[7])
		else $error("math error not flagged");
	AST_FT_HOLD: assert property (
		faultFlags_r[7] && !clearStatus && !(cmdValid && cmdCode == 3'h2)
		|=> $stable(faultFlags_r[7]))
		else $error("fault flag dropped");
	AST_RD_DATA: assert property (
		cmdValid && cmdCode == 3'h1 && !cmdBitForm
		|=> respValid_r && respData_r == $past(lockinFlags_r))
		else $error("whole read answer wrong");
	AST_SILENT: assert property (
		!(cmdValid && cmdCode inside {3'h1, 3'h2, 3'h3, 3'h4})
		|=> !respValid_r)
		else $error("answer without a read");
	AST_UNUSED: assert property (
		!lockinFlags_r[7] && !faultFlags_r[0] && !faultFlags_r[3])
		else $error("unused bit set");
	AST_SUM: assert property (
		lockinFlags_r == 8'h00 ##1 1'b1 |-> !lockinSummary_r)
		else $error("summary without flags");
endmodule : lsb_status_bank_props

bind lsb_status_bank lsb_status_bank_props u_props (
	.clk_sys, .rst, .cmdValid, .cmdCode, .cmdBitForm, .clearStatus,
	.inputOverload, .storageTrigger, .extTriggerMode, .mathError,
	.respData_r, .respValid_r, .lockinFlags_r, .faultFlags_r,
	.lockinSummary_r
);

// ==== testbench/lsb_host_model.sv ====
/* Remote controller model: one command strobe per transfer.
   Assumes answers are registered on the take edge and read just after it. */
module lsb_host_model (
	// clock
	input  wire logic       clk_sys,
	// command port
	output logic            cmdValid,
	output logic      [2:0] cmdCode,
	output logic            cmdBitForm,
	output logic      [2:0] cmdBitSel,
	output logic      [7:0] cmdData,
	// answers
	input  wire logic [7:0] respData_r,
	input  wire logic       respValid_r
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmdValid = 1'b0;
		{cmdCode, cmdBitForm, cmdBitSel, cmdData} = 15'h0000;
	end
	task automatic xfer(input logic [2:0] c, input logic b,
		input logic [2:0] s, input logic [7:0] w,
		output logic [7:0] d, output logic v);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		{cmdCode, cmdBitForm, cmdBitSel, cmdData} <= {c, b, s, w};
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		// stale write data must never pass for a held request
		cmdData <= ~w;
		#1;
		v = respValid_r;
		d = respData_r;
	endtask : xfer
endmodule : lsb_host_model

// ==== testbench/tb.sv ====
/* Bench for the status byte bank: events, pins and settings in,
   bytes read back through the host model. Assumes the bound checker. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys = 1'b0, rst = 1'b1, clearStatus = 1'b0;
	logic [5:0]  lkEv = 6'h00;
	logic [4:0]  ftEv = 5'h00, tcReqIdx = 5'h00, addrWriteVal = 5'h00;
	logic        extTriggerMode = 1'b0, detFreqValid = 1'b0;
	logic [31:0] detFreqMhz = 32'h0;
	logic        syncFilterReq = 1'b0, batteryFailPin = 1'b0;
	logic        setupKeyPin = 1'b0, addrWrite = 1'b0;
	logic        savedAddrValid = 1'b0;
	logic [4:0]  savedAddr = 5'h03;
	logic        cmdValid, cmdBitForm, respValid_r, v;
	logic        lockinSummary_r, faultSummary_r;
	logic        upperRange_r, syncFilterEn_r;
	logic [2:0]  cmdCode, cmdBitSel;
	logic [7:0]  cmdData, respData_r, lockinFlags_r, faultFlags_r, d;
	logic [4:0]  effTcIdx_r, busAddr_r;
	int          n_errors = 0;
	int          tests_run = 0;
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	lsb_host_model host (.clk_sys, .cmdValid, .cmdCode, .cmdBitForm,
		.cmdBitSel, .cmdData, .respData_r, .respValid_r);
	lsb_status_bank #(.TC_LIMIT_IDX(5'h11)) DUT (.clk_sys, .rst,
		.cmdValid, .cmdCode, .cmdBitForm, .cmdBitSel, .cmdData,
		.clearStatus, .respData_r, .respValid_r,
		.inputOverload(lkEv[0]), .filterOverload(lkEv[1]),
		.outputOverload(lkEv[2]), .lockLost(lkEv[3]),
		.tcIndirectChange(lkEv[4]), .storageTrigger(lkEv[5]),
		.extTriggerMode, .detFreqValid, .detFreqMhz, .tcReqIdx,
		.syncFilterReq, .ramTestError(ftEv[0]), .romTestError(ftEv[1]),
		.fastAbort(ftEv[2]), .dspTestError(ftEv[3]), .mathError(ftEv[4]),
		.batteryFailPin, .setupKeyPin, .addrWrite, .addrWriteVal,
		.savedAddrValid, .savedAddr, .lockinFlags_r, .faultFlags_r,
		.lockinSummary_r, .faultSummary_r, .upperRange_r,
		.syncFilterEn_r, .effTcIdx_r, .busAddr_r);
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic ev(input logic [5:0] l, input logic [4:0] f,
		input logic c, input int n);
		@(posedge clk_sys);
		{lkEv, ftEv, clearStatus} <= {l, f, c};
		@(posedge clk_sys);
		{lkEv, ftEv, clearStatus} <= 12'h000;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : ev
	// pins settle during the whole reset, well over the two sync stages
	task automatic boot(input logic b, k, s);
		@(posedge clk_sys);
		{rst, batteryFailPin, setupKeyPin, savedAddrValid} <= {1'b1, b, k, s};
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : boot
	task automatic setF(input logic [31:0] f, e, t);
		@(posedge clk_sys);
		detFreqMhz <= f;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("upper", e, upperRange_r);
		chk("tc", t, {syncFilterEn_r, effTcIdx_r});
	endtask : setF
	////////////////////////////////////////
	task automatic t_boot();
		boot(1'b0, 1'b0, 1'b0);
		chk("addr", 32'h08, busAddr_r);
		boot(1'b1, 1'b0, 1'b1);
		chk("backup", 32'h02, faultFlags_r);
		chk("saved", 32'h03, busAddr_r);
		@(posedge clk_sys);
		{addrWrite, addrWriteVal} <= {1'b1, 5'h0C};
		@(posedge clk_sys);
		addrWrite <= 1'b0;
		#1;
		chk("newaddr", 32'h0C, busAddr_r);
		boot(1'b0, 1'b1, 1'b1);
		chk("keyaddr", 32'h08, busAddr_r);
	endtask : t_boot
	task automatic t_lock();
		logic [7:0] e;
		e = 8'h00;
		ev(6'h20, 5'h00, 1'b0, 0);
		chk("trigoff", 32'h0, lockinFlags_r);
		@(posedge clk_sys);
		extTriggerMode <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			ev(6'h01 << i, 5'h00, 1'b0, 0);
			e[i < 4 ? i : i + 1] = 1'b1;
			chk("lkbit", e, lockinFlags_r);
		end
		ev(6'h00, 5'h00, 1'b0, 3);
		chk("lkhold", 32'h6F, lockinFlags_r);
		host.xfer(3'h1, 1'b1, 3'h5, 8'h00, d, v);
		chk("lkbitrd", 32'h101, {v, d});
		chk("lkleft", 32'h4F, lockinFlags_r);
		host.xfer(3'h1, 1'b0, 3'h0, 8'h00, d, v);
		chk("lkrd", 32'h14F, {v, d});
		chk("lkclr", 32'h0, lockinFlags_r);
	endtask : t_lock
	task automatic t_fault();
		ev(6'h00, 5'h1F, 1'b0, 3);
		chk("ft", 32'hF4, faultFlags_r);
		host.xfer(3'h2, 1'b1, 3'h4, 8'h00, d, v);
		chk("ftbit", 32'h101, {v, d});
		chk("ftleft", 32'hE4, faultFlags_r);
		// set beats clear in the same cycle
		ev(6'h01, 5'h00, 1'b1, 0);
		chk("cls", 32'h0100, {lockinFlags_r, faultFlags_r});
		ev(6'h00, 5'h00, 1'b1, 0);
		chk("cls2", 32'h0, lockinFlags_r);
	endtask : t_fault
	task automatic t_range();
		@(posedge clk_sys);
		{tcReqIdx, syncFilterReq, detFreqValid} <= {5'h1F, 1'b1, 1'b1};
		setF(32'h0003_1970, 32'h0, 32'h3F);
		setF(32'h0003_1971, 32'h1, 32'h11);
		chk("rngflag", 32'h1, lockinFlags_r[4]);
		setF(32'h0003_0A2A, 32'h1, 32'h11);
		setF(32'h0003_0A29, 32'h0, 32'h3F);
		host.xfer(3'h1, 1'b0, 3'h0, 8'h00, d, v);
		chk("rngrd", 32'h130, {v, d});
	endtask : t_range
	task automatic t_enable();
		host.xfer(3'h5, 1'b0, 3'h0, 8'h01, d, v);
		host.xfer(3'h5, 1'b1, 3'h3, 8'h01, d, v);
		chk("wrquiet", 32'h0, v);
		host.xfer(3'h3, 1'b0, 3'h0, 8'h00, d, v);
		chk("lken", 32'h109, {v, d});
		host.xfer(3'h3, 1'b1, 3'h3, 8'h00, d, v);
		chk("lkenbit", 32'h101, {v, d});
		host.xfer(3'h6, 1'b0, 3'h0, 8'h80, d, v);
		host.xfer(3'h4, 1'b0, 3'h0, 8'h00, d, v);
		chk("ften", 32'h180, {v, d});
		host.xfer(3'h7, 1'b0, 3'h0, 8'h00, d, v);
		chk("noop", 32'h0, v);
		ev(6'h04, 5'h10, 1'b0, 1);
		chk("sum", 32'h1, {lockinSummary_r, faultSummary_r});
		ev(6'h08, 5'h00, 1'b1, 1);
		chk("sum2", 32'h2, {lockinSummary_r, faultSummary_r});
	endtask : t_enable
	////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		t_boot();
		t_lock();
		t_fault();
		t_range();
		t_enable();
		complete_run();
	end
	// whole run is about 125 cycles; this leaves a wide margin
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
endmodule : tb
